// *** supply_monitor_cfg.svh ***
// constants for the supply monitor and sequencer
// assumes byte-wide register port at documented offsets
`ifndef SUPPLY_MONITOR_CFG_SVH
`define SUPPLY_MONITOR_CFG_SVH
`define SUPPLY_IRQ_EN_OFFSET    8'h04
`define SUPPLY_STATUS_OFFSET    8'h05
`define SUPPLY_IRQ_EN_RESET     8'h00
`define SUPPLY_STATUS_RESET     8'h00
`define BIT_REG_OVERVOLT        4
`define BIT_REG_HOT             3
`define BIT_HIGHSIDE_HIGH       2
`define BIT_MAIN_LOW            1
`define BIT_BATTERY_LOW         0
`define SUPPLY_FIELD_MASK       8'h1F
`endif

// *** supply_monitor_pkg.sv ***
// types for the supply monitor and sequencer
// shared by the flag latch and the top module
package supply_monitor_pkg;
    // one bit per warning source, bit order as in the registers
    typedef struct packed {
        logic regulator_overvolt;
        logic regulator_hot;
        logic highside_supply_high;
        logic main_supply_low;
        logic battery_low;
    } warn_vec_t;

    typedef enum logic [3:0] {
        SEQ_OFF      = 4'h1,
        SEQ_CORE_UP  = 4'h2,
        SEQ_RUN      = 4'h4,
        SEQ_DISCHG   = 4'h8
    } seq_state_t;
endpackage

// *** supply_flag_latch.sv ***
// sticky interrupt flags for the five warning sources
// assumes conditions are already synchronised to mclk
`timescale 1ns/1ps
module supply_flag_latch
    import supply_monitor_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      sys_rst,
    input  wire warn_vec_t cond,
    input  wire logic      clear,
    output warn_vec_t      flags
);
    warn_vec_t cond_prev_q;
    warn_vec_t flags_q;

    // previous condition level for rising edge detection
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cond_prev_q <= '0;
        end else begin
            cond_prev_q <= cond;
        end
    end

    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flags_q <= '0;
        end else begin
            flags_q <= (clear ? warn_vec_t'('0) : flags_q) | (cond & ~cond_prev_q);
        end
    end

    assign flags = flags_q;

    flag_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (cond.battery_low && !cond_prev_q.battery_low) |=> flags_q.battery_low)
        else $error("battery low flag not set on rising condition");
endmodule // supply_flag_latch

// *** supply_monitor_sequencer.sv ***
// supply sequencer and warning register block of the analog die
// assumes comparator outputs are asynchronous; register port is same-clock byte bus
`timescale 1ns/1ps
`include "supply_monitor_cfg.svh"
module supply_monitor_sequencer
    import supply_monitor_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       io_supply_ok,
    input  wire logic       core_supply_ok,
    input  wire warn_vec_t  warn_raw,
    input  wire logic       normal_mode,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       irq_ack,
    output logic [7:0]      reg_rdata,
    output logic            core_reg_en,
    output logic            core_discharge,
    output logic            die_reset_n,
    output logic            combined_supply_irq,
    output logic            die_link_irq_out
);
    logic       io_ok_s1_q;
    logic       io_ok_q;
    logic       core_ok_s1_q;
    logic       core_ok_q;
    warn_vec_t  warn_s1_q;
    warn_vec_t  warn_q;
    seq_state_t state_q;
    logic [7:0] irq_en_q;
    logic [7:0] rdata_q;
    logic       link_irq_q;
    warn_vec_t  flags;
    warn_vec_t  gated;
    logic       status_rd;

    // two-stage synchronisers for all analog comparator outputs
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            io_ok_s1_q   <= 1'b0;
            io_ok_q      <= 1'b0;
            core_ok_s1_q <= 1'b0;
            core_ok_q    <= 1'b0;
            warn_s1_q    <= '0;
            warn_q       <= '0;
        end else begin
            io_ok_s1_q   <= io_supply_ok;
            io_ok_q      <= io_ok_s1_q;
            core_ok_s1_q <= core_supply_ok;
            core_ok_q    <= core_ok_s1_q;
            warn_s1_q    <= warn_raw;
            warn_q       <= warn_s1_q;
        end
    end

    // power sequencing; io supply loss overrides SEQ_CORE_UP and SEQ_RUN, sending both to SEQ_DISCHG
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= SEQ_OFF;
        end else begin
            case (state_q)
                SEQ_OFF: begin
                    if (io_ok_q) state_q <= SEQ_CORE_UP;
                end
                SEQ_CORE_UP: begin
                    if (!io_ok_q) state_q <= SEQ_DISCHG;
                    else if (core_ok_q) state_q <= SEQ_RUN;
                end
                SEQ_RUN: begin
                    if (!io_ok_q) state_q <= SEQ_DISCHG;
                end
                SEQ_DISCHG: begin
                    // core kept pulled low until the io supply returns
                    if (io_ok_q) state_q <= SEQ_CORE_UP;
                end
                default: state_q <= SEQ_OFF;
            endcase
        end
    end

    // sequencer outputs decoded straight from the one-hot state
    assign core_reg_en    = (state_q == SEQ_CORE_UP) || (state_q == SEQ_RUN);
    assign core_discharge = (state_q == SEQ_DISCHG);
    assign die_reset_n    = (state_q == SEQ_RUN);

    // enable register write; upper bits are not stored
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_en_q <= `SUPPLY_IRQ_EN_RESET;
        end else if (reg_wr && reg_addr == `SUPPLY_IRQ_EN_OFFSET) begin
            irq_en_q <= reg_wdata & `SUPPLY_FIELD_MASK;
        end
    end

    assign status_rd = reg_rd && (reg_addr == `SUPPLY_STATUS_OFFSET);

    // sticky flags, cleared by any status read
    supply_flag_latch u_flags (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .cond    (warn_q),
        .clear   (status_rd),
        .flags   (flags)
    );

    // per-source gating by the enable bits
    assign gated.regulator_overvolt   = flags.regulator_overvolt
                                        & irq_en_q[`BIT_REG_OVERVOLT];
    assign gated.regulator_hot        = flags.regulator_hot
                                        & irq_en_q[`BIT_REG_HOT];
    assign gated.highside_supply_high = flags.highside_supply_high
                                        & irq_en_q[`BIT_HIGHSIDE_HIGH];
    assign gated.main_supply_low      = flags.main_supply_low
                                        & irq_en_q[`BIT_MAIN_LOW];
    assign gated.battery_low          = flags.battery_low
                                        & irq_en_q[`BIT_BATTERY_LOW];
    assign combined_supply_irq        = |gated;

    // read data registered; status shows live conditions, not flags
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `SUPPLY_IRQ_EN_OFFSET) begin
                rdata_q <= irq_en_q;
            end else if (reg_addr == `SUPPLY_STATUS_OFFSET) begin
                rdata_q <= {3'h0, warn_q};
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end
    assign reg_rdata = rdata_q;

    // link interrupt: set in normal mode, held until acknowledged or normal mode ends; set wins
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            link_irq_q <= 1'b0;
        end else if (combined_supply_irq && normal_mode) begin
            link_irq_q <= 1'b1;
        end else if (irq_ack || !normal_mode) begin
            link_irq_q <= 1'b0;
        end
    end
    assign die_link_irq_out = link_irq_q;

    sequence io_lost_s;
        $fell(io_ok_q);
    endsequence

    // core enable may only rise on an edge at which the io supply was seen good
    core_wait_io_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(core_reg_en) |-> $past(io_ok_q))
        else $error("core regulator on before io supply ok");
    reset_release_a: assert property (@(posedge mclk) disable iff (sys_rst)
        die_reset_n |-> $past(core_ok_q) || $past(die_reset_n))
        else $error("reset released before core supply ok");
    io_loss_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
        io_lost_s |=> core_discharge && !core_reg_en && !die_reset_n)
        else $error("io loss did not shut down core");
    en4_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !irq_en_q[`BIT_REG_OVERVOLT] && (flags == warn_vec_t'(5'h10))
        |-> !combined_supply_irq)
        else $error("overvolt request while disabled");
    status_live_a: assert property (@(posedge mclk) disable iff (sys_rst)
        status_rd |=> rdata_q == {3'h0, $past(warn_q)})
        else $error("status read data mismatch");
    rd_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        status_rd && !(warn_q.regulator_hot && !u_flags.cond_prev_q.regulator_hot)
        |=> !flags.regulator_hot)
        else $error("status read did not clear hot flag");
    irq_mode_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !normal_mode |=> !die_link_irq_out)
        else $error("interrupt asserted outside normal mode");
    irq_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        die_link_irq_out && !irq_ack && normal_mode |=> die_link_irq_out)
        else $error("interrupt dropped without acknowledge");
endmodule // supply_monitor_sequencer

// *** mcu_link_model.sv ***
// microcontroller side model: byte register accesses and interrupt acknowledge
// assumes same-clock bus; strobes last one cycle, driven 1 ns after the rising edge
`timescale 1ns/1ps
module mcu_link_model (
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_wdata,
    output logic            irq_ack
);
    // idle bus at time zero so no request is seen during reset
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
        irq_ack   = 1'b0;
    end

    // one-cycle write strobe; released data is inverted so stale bytes never look valid
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk);
        #1;
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~addr;
        reg_wdata = ~data;
    endtask

    // read data is registered at the strobe edge, so it is settled 1 ns later
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge mclk);
        #1;
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~addr;
        data     = reg_rdata;
    endtask

    // acknowledge pulse, one cycle wide
    task automatic ack_irq();
        @(posedge mclk);
        #1;
        irq_ack = 1'b1;
        @(posedge mclk);
        #1;
        irq_ack = 1'b0;
    endtask
endmodule // mcu_link_model

// *** supply_monitor_sequencer_test.sv ***
// self-checking bench for the supply sequencer and warning registers
// assumes the microcontroller model drives the register port and acknowledge
`timescale 1ns/1ps
module supply_monitor_sequencer_test;
    import supply_monitor_pkg::*;
    logic       mclk, sys_rst, io_supply_ok, core_supply_ok, normal_mode;
    warn_vec_t  warn_raw;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic       reg_wr, reg_rd, irq_ack, core_reg_en, core_discharge;
    logic       die_reset_n, combined_supply_irq, die_link_irq_out;
    logic [2:0] watched;
    int         fails, total_checks;
    assign watched = {die_link_irq_out, die_reset_n, core_reg_en};

    supply_monitor_sequencer u_supply_monitor_sequencer (.mclk(mclk), .sys_rst(sys_rst),
        .io_supply_ok(io_supply_ok), .core_supply_ok(core_supply_ok), .warn_raw(warn_raw),
        .normal_mode(normal_mode), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .irq_ack(irq_ack), .reg_rdata(reg_rdata),
        .core_reg_en(core_reg_en), .core_discharge(core_discharge), .die_reset_n(die_reset_n),
        .combined_supply_irq(combined_supply_irq), .die_link_irq_out(die_link_irq_out));
    mcu_link_model u_mcu_link_model (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .irq_ack(irq_ack));

    // 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // bounded wait on one watched output; running out counts as a mismatch
    task automatic wait_lvl(input int sel, input logic lvl);
        int n;
        n = 0;
        while (watched[sel] !== lvl && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (watched[sel] !== lvl) begin
            fails++;
            report_and_stop();
        end
    endtask

    task automatic scen_power_up();
        check({core_reg_en, die_reset_n}, 8'h00);
        io_supply_ok = 1'b1;
        wait_lvl(0, 1'b1);
        check(die_reset_n, 8'h00);
        core_supply_ok = 1'b1;
        wait_lvl(1, 1'b1);
    endtask

    // enable reads back only bits 4:0; status is read-only; holes read zero
    task automatic scen_registers();
        u_mcu_link_model.write_reg(8'h04, 8'hFF);
        u_mcu_link_model.read_reg(8'h04, rd);
        check(rd, 8'h1F);
        u_mcu_link_model.write_reg(8'h05, 8'hFF);
        u_mcu_link_model.read_reg(8'h05, rd);
        check(rd, 8'h00);
        u_mcu_link_model.read_reg(8'h07, rd);
        check(rd, 8'h00);
    endtask

    // each source: masked, then enabled on a latched flag, then cleared by a status read
    task automatic scen_sources();
        for (int i = 0; i < 5; i++) begin
            u_mcu_link_model.write_reg(8'h04, ~(8'h01 << i));
            warn_raw = warn_vec_t'(5'h01 << i);
            repeat (4) @(posedge mclk);
            #1;
            check(combined_supply_irq, 8'h00);
            u_mcu_link_model.write_reg(8'h04, 8'h01 << i);
            check(combined_supply_irq, 8'h01);
            wait_lvl(2, 1'b1);
            u_mcu_link_model.read_reg(8'h05, rd);
            check(rd, 8'h01 << i);
            check(combined_supply_irq, 8'h00);
            u_mcu_link_model.ack_irq();
            check(die_link_irq_out, 8'h00);
            warn_raw = '0;
            repeat (4) @(posedge mclk);
            #1;
        end
        // leaving normal mode drops a pending interrupt; only overvolt is enabled now
        warn_raw = warn_vec_t'(5'h10);
        wait_lvl(2, 1'b1);
        normal_mode = 1'b0;
        wait_lvl(2, 1'b0);
    endtask

    // io loss shuts the core down; io return restarts it through the reset hold
    task automatic scen_power_down();
        io_supply_ok = 1'b0;
        wait_lvl(0, 1'b0);
        check({core_discharge, die_reset_n}, 8'h02);
        io_supply_ok = 1'b1;
        wait_lvl(0, 1'b1);
        check({core_discharge, die_reset_n}, 8'h00);
        wait_lvl(1, 1'b1);
    endtask

    // reset in mid-run returns outputs and enables to idle, then power-up restarts
    task automatic scen_mid_reset();
        @(posedge mclk);
        #1;
        sys_rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        check({core_discharge, watched}, 8'h00);
        u_mcu_link_model.read_reg(8'h04, rd);
        check(rd, 8'h00);
        wait_lvl(0, 1'b1);
    endtask

    initial begin
        fails = 0;
        total_checks = 0;
        sys_rst = 1'b1;
        io_supply_ok = 1'b0;
        core_supply_ok = 1'b0;
        normal_mode = 1'b1;
        warn_raw = '0;
        repeat (6) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        scen_power_up();
        scen_registers();
        scen_sources();
        scen_power_down();
        scen_mid_reset();
        report_and_stop();
    end
endmodule // supply_monitor_sequencer_test
